// [hdl/dtc_defines.svh]
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// Clock and tone timing.
`define DTC_CLK_FREQ_HZ    20000000
`define DTC_BURST_TIME_MS  51
`define DTC_CP_FACTOR      2
`define DTC_BURST_CYC      (`DTC_BURST_TIME_MS * (`DTC_CLK_FREQ_HZ / 1000))

// Register select line decode.
`define DTC_RS_DATA        1'b0
`define DTC_RS_CTRL        1'b1

// First control register fields.
`define DTC_CRA_TONE_OUTPUT_ENABLE       0
`define DTC_CRA_CP         1
`define DTC_CRA_IRQ        2
`define DTC_CRA_REDIR      3

// Second control register fields.
`define DTC_CRB_BURST_OFF  0
`define DTC_CRB_RX_OFF     1
`define DTC_CRB_SINGLE     2
`define DTC_CRB_COLUMN     3

// Status register fields.
`define DTC_STS_IRQ        0
`define DTC_STS_TX_EMPTY   1
`define DTC_STS_RX_FULL    2
`define DTC_STS_STEER      3

// Reset values.
`define DTC_CRA_RESET      4'h0
`define DTC_CRB_RESET      4'h0
`define DTC_STS_RESET      4'h0
`define DTC_TXD_RESET      4'h0
`define DTC_RXD_RESET      4'h0

`endif

// [hdl/dtc_pkg.sv]
package dtc_pkg;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic       register_select_line;
		logic [3:0] data;
	} dtc_req_s;

	typedef struct packed {
		logic second_control_redirect;
		logic irq_enable;
		logic call_progress_select;
		logic tone_output_enable;
	} dtc_cra_s;

	typedef struct packed {
		logic column_select;
		logic single_select;
		logic receiver_power_off;
		logic burst_off;
	} dtc_crb_s;

	typedef struct packed {
		logic steer_delayed;
		logic rx_full;
		logic tx_empty;
		logic irq_flag;
	} dtc_status_s;

	typedef enum logic [2:0] {
		DTC_IDLE  = 3'b001,
		DTC_TONE  = 3'b010,
		DTC_PAUSE = 3'b100
	} dtc_burst_e;

endpackage : dtc_pkg

// [hdl/dtc_burst_timer.sv]
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_burst_timer
	import dtc_pkg::*;
#(
	parameter int P_BURST_CYC = `DTC_BURST_CYC
) (
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_rstn,
	// Control.
	input  wire logic i_start,
	input  wire logic i_double,
	input  wire logic i_abort,
	// Status.
	output logic      o_tone,
	output logic      o_busy,
	output logic      o_done
);

	dtc_burst_e  state_q;
	logic [21:0] cnt_q;
	logic        done_q;

	function automatic logic [21:0] dtc_dur(input logic dbl);
		int cyc;
		cyc = dbl ? (P_BURST_CYC * `DTC_CP_FACTOR) : P_BURST_CYC;
		return 22'(cyc - 1);
	endfunction : dtc_dur

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_q <= DTC_IDLE;
			cnt_q   <= 22'h0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (i_abort) begin
				state_q <= DTC_IDLE;
				cnt_q   <= 22'h0;
			end else begin
				unique case (state_q)
					DTC_IDLE: begin
						if (i_start) begin
							state_q <= DTC_TONE;
							cnt_q   <= dtc_dur(i_double);
						end
					end
					DTC_TONE: begin
						if (cnt_q == 22'h0) begin
							state_q <= DTC_PAUSE;
							cnt_q   <= dtc_dur(i_double);
						end else begin
							cnt_q <= cnt_q - 22'h1;
						end
					end
					DTC_PAUSE: begin
						if (cnt_q == 22'h0) begin
							state_q <= DTC_IDLE;
							done_q  <= 1'b1;
						end else begin
							cnt_q <= cnt_q - 22'h1;
						end
					end
					default: begin
						state_q <= DTC_IDLE;
					end
				endcase
			end
		end
	end

	assign o_tone = (state_q == DTC_TONE);
	assign o_busy = (state_q != DTC_IDLE);
	assign o_done = done_q;

	burst_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(state_q == DTC_IDLE && i_start && !i_abort) |=>
		(cnt_q == dtc_dur($past(i_double))))
		else $error("burst length loaded wrong");

endmodule : dtc_burst_timer

// [hdl/dtc_transceiver_ctrl.sv]
`timescale 1ns/1ps
`include "dtc_defines.svh"

// Behaviour
// - Second control bit 0 low enables burst mode, high disables it.
// - Burst mode: each transmit write with tone output enable set and no burst running gives equal tone burst and pause.
// - After the pause, transmit-empty flag sets and interrupt may fire.
// - Call progress mode doubles burst and pause lengths.
// - Without burst mode, tone lasts while tone output enable is set.
// - Second control bit 1 high powers both receivers down.
// - Second control bit 2 high selects single tone, low dual.
// - Bit 3 picks column or row tone, only in single tone.
// - Transmitter and receiver both down also stops oscillator and reference.
// - Interrupt flag sets with either event flag, clears on status read.
// - Transmit-empty sets after burst pause; cleared by read or burst off.
// - Receive-full sets on a valid digit; cleared by status read.
// - Delayed steering sets on tone absence, clears on valid tone.
// - Redirect bit sends exactly the next control write to second register.
// - Tone output enable low powers transmitter down and clears data.
// - Select line high: write goes to control, read returns status.
// - Interrupt pin pulls low on digit or transmit ready in DTMF mode.

module dtc_transceiver_ctrl
	import dtc_pkg::*;
#(
	parameter int P_BURST_CYC = `DTC_BURST_CYC
) (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Host register access.
	input  wire dtc_req_s   i_req,
	output logic [3:0]      o_rdata,
	output logic            o_rvalid,
	// Receiver side.
	input  wire logic       i_rx_digit_valid,
	input  wire logic [3:0] i_rx_digit,
	input  wire logic       i_rx_absent,
	input  wire logic       i_rx_present,
	input  wire logic       i_cp_square,
	// Transmitter side.
	output logic            o_tone_active,
	output logic [3:0]      o_tone_code,
	output logic            o_tone_single,
	output logic            o_tone_column,
	output logic            o_tone_drive_oe,
	// Power control.
	output logic            o_tx_power_off,
	output logic            o_rx_power_off,
	output logic            o_osc_power_off,
	// Open-drain interrupt or call progress pin.
	output logic            o_interrupt_progress_pin_o,
	output logic            o_interrupt_progress_pin_oe
);

	dtc_cra_s    cra_q;
	dtc_crb_s    crb_q;
	dtc_status_s sts_q;
	logic        redirect_q;
	logic [3:0]  txd_q;
	logic [3:0]  rxd_q;
	logic [3:0]  rdata_q;
	logic        rvalid_q;
	logic        tone_q;
	logic        column_q;
	logic        irq_oe_q;

	logic        wr;
	logic        rd;
	logic        ctrl_wr;
	logic        tx_wr;
	logic        sts_rd;
	logic        burst_en;
	logic        tmr_start;
	logic        tmr_abort;
	logic        tmr_tone;
	logic        tmr_busy;
	logic        tmr_done;
	logic        set_tx;
	logic        set_rx;

	// Access decode.
	assign wr      = i_req.valid & i_req.write;
	assign rd      = i_req.valid & ~i_req.write;
	assign ctrl_wr = wr & (i_req.register_select_line == `DTC_RS_CTRL);
	assign tx_wr   = wr & (i_req.register_select_line == `DTC_RS_DATA);
	assign sts_rd  = rd & (i_req.register_select_line == `DTC_RS_CTRL);

	assign burst_en = ~crb_q.burst_off;

	// A digit written while a burst is running is dropped.
	assign tmr_start = tx_wr & burst_en & cra_q.tone_output_enable
		& ~tmr_busy;
	assign tmr_abort = ~cra_q.tone_output_enable | ~burst_en;

	assign set_tx = tmr_done & burst_en;
	assign set_rx = i_rx_digit_valid & ~crb_q.receiver_power_off;

	dtc_burst_timer #(
		.P_BURST_CYC (P_BURST_CYC)
	) u_timer (
		.i_clk    (i_clk),
		.i_rstn   (i_rstn),
		.i_start  (tmr_start),
		.i_double (cra_q.call_progress_select),
		.i_abort  (tmr_abort),
		.o_tone   (tmr_tone),
		.o_busy   (tmr_busy),
		.o_done   (tmr_done)
	);

	// Shared control address; the redirect arms exactly one write.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			redirect_q <= 1'b0;
		end else if (ctrl_wr) begin
			redirect_q <= ~redirect_q
				& i_req.data[`DTC_CRA_REDIR];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cra_q <= `DTC_CRA_RESET;
		end else if (ctrl_wr && !redirect_q) begin
			cra_q <= i_req.data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			crb_q <= `DTC_CRB_RESET;
		end else if (ctrl_wr && redirect_q) begin
			crb_q <= i_req.data;
		end
	end

	// Transmit data register.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			txd_q <= `DTC_TXD_RESET;
		end else if (!cra_q.tone_output_enable) begin
			txd_q <= `DTC_TXD_RESET;
		end else if (tx_wr && (!burst_en || !tmr_busy)) begin
			txd_q <= i_req.data;
		end
	end

	// Receive data register.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rxd_q <= `DTC_RXD_RESET;
		end else if (set_rx) begin
			rxd_q <= i_rx_digit;
		end
	end

	// Status flags; a new event wins over a clearing read.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			sts_q <= `DTC_STS_RESET;
		end else begin
			sts_q.irq_flag <= set_tx | set_rx
				| (sts_q.irq_flag & ~sts_rd);
			if (!burst_en) begin
				sts_q.tx_empty <= 1'b0;
			end else begin
				sts_q.tx_empty <= set_tx
					| (sts_q.tx_empty & ~sts_rd);
			end
			sts_q.rx_full <= set_rx
				| (sts_q.rx_full & ~sts_rd);
			if (i_rx_absent) begin
				sts_q.steer_delayed <= 1'b1;
			end else if (i_rx_present) begin
				sts_q.steer_delayed <= 1'b0;
			end
		end
	end

	// Read data path.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rdata_q  <= 4'h0;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rd;
			if (rd) begin
				rdata_q <= i_req.register_select_line
					? sts_q : rxd_q;
			end
		end
	end

	// Tone generator controls.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tone_q   <= 1'b0;
			column_q <= 1'b0;
		end else begin
			tone_q   <= cra_q.tone_output_enable
				& (burst_en ? tmr_tone : 1'b1);
			// Loaded with the register so it never lags the single bit.
			if (ctrl_wr && redirect_q) begin
				column_q <= i_req.data[`DTC_CRB_SINGLE]
					& i_req.data[`DTC_CRB_COLUMN];
			end
		end
	end

	// Interrupt pin; in call progress mode it mirrors the square wave.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			irq_oe_q <= 1'b0;
		end else if (!cra_q.irq_enable) begin
			irq_oe_q <= 1'b0;
		end else if (cra_q.call_progress_select) begin
			irq_oe_q <= ~i_cp_square;
		end else begin
			irq_oe_q <= sts_q.irq_flag;
		end
	end

	assign o_rdata         = rdata_q;
	assign o_rvalid        = rvalid_q;
	assign o_tone_active   = tone_q;
	assign o_tone_code     = txd_q;
	assign o_tone_single   = crb_q.single_select;
	assign o_tone_column   = column_q;
	assign o_tone_drive_oe = cra_q.tone_output_enable;
	assign o_tx_power_off  = ~cra_q.tone_output_enable;
	assign o_rx_power_off  = crb_q.receiver_power_off;
	assign o_osc_power_off = ~cra_q.tone_output_enable
		& crb_q.receiver_power_off;
	assign o_interrupt_progress_pin_o  = 1'b0;
	assign o_interrupt_progress_pin_oe = irq_oe_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence redirect_arm_s;
		ctrl_wr && !redirect_q && i_req.data[`DTC_CRA_REDIR];
	endsequence

	sequence burst_done_s;
		tmr_done && burst_en;
	endsequence

	redirect_arm_a: assert property (
		redirect_arm_s |=> redirect_q)
		else $error("redirect not armed by first register write");

	redirect_write_a: assert property (
		ctrl_wr && redirect_q |=>
		(crb_q == $past(i_req.data)) && !redirect_q)
		else $error("second control write not redirected");

	redirect_once_a: assert property (
		ctrl_wr && !redirect_q |=>
		(cra_q == $past(i_req.data)))
		else $error("write after redirect missed first register");

	burst_off_a: assert property (
		crb_q.burst_off |=> !sts_q.tx_empty)
		else $error("transmit empty set outside burst mode");

	tx_ready_a: assert property (
		burst_done_s |=> sts_q.tx_empty && sts_q.irq_flag)
		else $error("pause end did not flag transmit empty");

	irq_follow_a: assert property (
		$rose(sts_q.rx_full) || $rose(sts_q.tx_empty) |-> sts_q.irq_flag)
		else $error("interrupt flag missing with event");

	read_clear_a: assert property (
		sts_rd && !set_rx && !set_tx |=>
		!sts_q.rx_full && !sts_q.irq_flag)
		else $error("status read did not clear flags");

	steer_clear_a: assert property (
		i_rx_present && !i_rx_absent |=> !sts_q.steer_delayed)
		else $error("delayed steering not cleared");

	tone_off_a: assert property (
		!cra_q.tone_output_enable |-> !o_tone_drive_oe
		##1 ((txd_q == 4'h0) && !o_tone_active))
		else $error("tone output enable low left transmitter on");

	steady_tone_a: assert property (
		crb_q.burst_off && cra_q.tone_output_enable |=> o_tone_active)
		else $error("non-burst tone not following enable");

	column_only_a: assert property (
		o_tone_column |-> o_tone_single)
		else $error("column tone without single tone");

	osc_power_a: assert property (
		o_osc_power_off |-> o_tx_power_off && o_rx_power_off)
		else $error("oscillator off while a section runs");

	irq_pin_a: assert property (
		cra_q.irq_enable && !cra_q.call_progress_select
		&& $past(cra_q.irq_enable) && !$past(cra_q.call_progress_select)
		|-> (o_interrupt_progress_pin_oe == $past(sts_q.irq_flag)))
		else $error("interrupt pin not tracking flag");

	irq_release_a: assert property (
		cra_q.irq_enable && !cra_q.call_progress_select && sts_rd
		&& !set_rx && !set_tx ##1 cra_q.irq_enable
		&& !cra_q.call_progress_select |=> !o_interrupt_progress_pin_oe)
		else $error("interrupt pin not released after read");

	status_read_a: assert property (
		sts_rd |=> o_rvalid && (o_rdata == $past(sts_q)))
		else $error("status read returned wrong data");

endmodule : dtc_transceiver_ctrl

// [tb/dtc_host_model.sv]
`timescale 1ns/1ps

module dtc_host_model
	import dtc_pkg::*;
(
	// Clock.
	input  wire logic       i_clk,
	// Register bus.
	output dtc_req_s        o_req,
	input  wire logic [3:0] i_rdata,
	input  wire logic       i_rvalid
);
	initial o_req = '0;

	// Idle data is inverted so a stale value is never mistaken for a write.
	task automatic wr(input logic rs, input logic [3:0] d);
		@(negedge i_clk);
		o_req = '{1'b1, 1'b1, rs, d};
		@(negedge i_clk);
		o_req = '{1'b0, 1'b0, 1'b0, ~d};
	endtask : wr

	task automatic rd(input logic rs, output logic [3:0] q);
		@(negedge i_clk);
		o_req = '{1'b1, 1'b0, rs, 4'h0};
		@(negedge i_clk);
		o_req = '{1'b0, 1'b0, 1'b0, 4'hf};
		q = (i_rvalid === 1'b1) ? i_rdata : 4'hx;
	endtask : rd

	// Start-up sequence that puts both control registers in a known state.
	task automatic init;
		logic [3:0] q;
		rd(1'b1, q);
		wr(1'b1, 4'h0);
		wr(1'b1, 4'h0);
		wr(1'b1, 4'h8);
		wr(1'b1, 4'h0);
		rd(1'b1, q);
	endtask : init
endmodule : dtc_host_model

// [tb/dtc_transceiver_ctrl_bench.sv]
`timescale 1ns/1ps

module dtc_transceiver_ctrl_bench
	import dtc_pkg::*;
;
	localparam int N = 20;
	logic       i_clk = 1'b0;
	logic       i_rstn = 1'b0;
	dtc_req_s   req;
	logic [3:0] rdata, t_code, q;
	logic [3:0] digit = 4'h0;
	logic       dvalid = 1'b0, absent = 1'b0, present = 1'b0;
	logic       rvalid, t_act, t_sgl, t_col, t_oe;
	logic       tx_off, rx_off, osc_off, pin_oe, pin_o;
	logic       cp_sq = 1'b0;
	int         fail_count = 0, n_checks = 0, cyc = 0, n;

	always #25 i_clk = ~i_clk;

	dtc_transceiver_ctrl #(.P_BURST_CYC(N)) u_dtc_transceiver_ctrl (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
		.o_rvalid(rvalid), .i_rx_digit_valid(dvalid), .i_rx_digit(digit),
		.i_rx_absent(absent), .i_rx_present(present), .i_cp_square(cp_sq),
		.o_tone_active(t_act), .o_tone_code(t_code), .o_tone_single(t_sgl),
		.o_tone_column(t_col), .o_tone_drive_oe(t_oe),
		.o_tx_power_off(tx_off), .o_rx_power_off(rx_off),
		.o_osc_power_off(osc_off), .o_interrupt_progress_pin_o(pin_o),
		.o_interrupt_progress_pin_oe(pin_oe));

	dtc_host_model u_dtc_host_model (
		.i_clk(i_clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic tick(input int k);
		repeat (k) @(negedge i_clk);
	endtask : tick

	task automatic setcr(input logic [3:0] a, input logic [3:0] b);
		u_dtc_host_model.wr(1'b1, a | 4'h8);
		u_dtc_host_model.wr(1'b1, b);
		tick(1);
	endtask : setcr

	task automatic rd_status(input logic [3:0] e);
		u_dtc_host_model.rd(1'b1, q);
		chk("status", {4'h0, e}, {4'h0, q});
	endtask : rd_status

	task automatic t_crb;
		setcr(4'h0, 4'hf);
		chk_bit("rx off", 1'b1, rx_off);
		chk_bit("single", 1'b1, t_sgl);
		chk_bit("column", 1'b1, t_col);
		chk_bit("osc off", 1'b1, osc_off);
		setcr(4'h0, 4'h8);
		chk_bit("column in dual", 1'b0, t_col);
		chk_bit("single off", 1'b0, t_sgl);
		chk_bit("osc on", 1'b0, osc_off);
		u_dtc_host_model.wr(1'b1, 4'h1);
		tick(1);
		chk_bit("tone drive", 1'b1, t_oe);
		chk_bit("second kept", 1'b0, rx_off);
	endtask : t_crb

	// Burst of one digit; call progress mode runs with interrupts off.
	task automatic t_burst(input logic cp, input int len);
		setcr({1'b0, ~cp, cp, 1'b1}, 4'h0);
		u_dtc_host_model.wr(1'b0, 4'h9);
		chk("tone code", 8'h9, {4'h0, t_code});
		n = 0;
		while (t_act !== 1'b1 && n < 5) begin
			tick(1);
			n++;
		end
		n = 0;
		while (t_act === 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		chk("burst length", 8'(len), 8'(n));
		if (!cp) begin
			n = 0;
			while (pin_oe !== 1'b1 && n < 300) begin
				tick(1);
				n++;
			end
			chk("pause length", 8'(len + 1), 8'(n));
		end else begin
			tick(len + 2);
		end
		rd_status(4'h3);
		tick(1);
		chk_bit("pin released", 1'b0, pin_oe);
		rd_status(4'h0);
	endtask : t_burst

	task automatic t_nonburst;
		setcr(4'h1, 4'h1);
		u_dtc_host_model.wr(1'b0, 4'h7);
		tick(2);
		chk_bit("tone on", 1'b1, t_act);
		u_dtc_host_model.wr(1'b1, 4'h0);
		tick(1);
		chk_bit("tone off", 1'b0, t_act);
		chk_bit("tone float", 1'b0, t_oe);
		chk_bit("tx power off", 1'b1, tx_off);
		chk("data cleared", 8'h0, {4'h0, t_code});
		rd_status(4'h0);
	endtask : t_nonburst

	task automatic t_receive;
		setcr(4'h4, 4'h0);
		digit = 4'h6;
		dvalid = 1'b1;
		tick(1);
		dvalid = 1'b0;
		digit = 4'h9;
		tick(1);
		chk_bit("pin on digit", 1'b1, pin_oe);
		u_dtc_host_model.rd(1'b0, q);
		chk("rx data", 8'h6, {4'h0, q});
		rd_status(4'h5);
		tick(1);
		chk_bit("pin cleared", 1'b0, pin_oe);
		absent = 1'b1;
		tick(1);
		absent = 1'b0;
		rd_status(4'h8);
		present = 1'b1;
		tick(1);
		present = 1'b0;
		rd_status(4'h0);
		// Call progress mode with interrupts on: pin follows the wave.
		setcr(4'h6, 4'h0);
		cp_sq = 1'b1;
		tick(2);
		chk_bit("pin cp high", 1'b0, pin_oe);
		cp_sq = 1'b0;
		tick(2);
		chk_bit("pin cp low", 1'b1, pin_oe);
	endtask : t_receive

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			print_verdict;
		end
	end

	initial begin
		tick(8);
		i_rstn = 1'b1;
		tick(1);
		chk_bit("reset tx off", 1'b1, tx_off);
		chk_bit("reset osc", 1'b0, osc_off);
		chk_bit("reset pin", 1'b0, pin_oe);
		chk_bit("pin level", 1'b0, pin_o);
		u_dtc_host_model.init;
		t_crb;
		t_burst(1'b0, N);
		t_burst(1'b1, 2 * N);
		t_nonburst;
		t_receive;
		print_verdict;
	end
endmodule : dtc_transceiver_ctrl_bench
